// ---- rla_defines.vh ----
`ifndef RLA_DEFINES_VH
`define RLA_DEFINES_VH

// Register byte offsets
`define RLA_OFF_USER_ID     7'h00
`define RLA_OFF_GROUP_ID    7'h04
`define RLA_OFF_EQUIP_ID    7'h08
`define RLA_OFF_DEST_ID     7'h0C
`define RLA_OFF_CHANNEL     7'h10
`define RLA_OFF_CTRL        7'h14
`define RLA_OFF_ROUTE_LEN   7'h18
`define RLA_OFF_STATUS      7'h1C
`define RLA_OFF_ROUTE_BASE  7'h20

// Reset values
`define RLA_RST_USER_ID     16'h0000
`define RLA_RST_GROUP_ID    8'h00
`define RLA_RST_EQUIP_ID    8'h01
`define RLA_RST_DEST_ID     8'h01
`define RLA_RST_CHANNEL     7'h00
`define RLA_RST_ROUTE_LEN   4'h0

// Field positions
`define RLA_CTRL_LVL_BIT    0

// Special identifier values
`define RLA_UID_FORBIDDEN   16'hFFFF
`define RLA_ID_BROADCAST    8'h00
`define RLA_ID_NULL         8'hFF
`define RLA_EID_SPECIAL     8'hFF

// Route list limits
`define RLA_MAX_RELAYS      4'hA
`define RLA_MAX_ROUTE       4'hB

// Transmit variants
`define RLA_VAR_BASIC       2'h1
`define RLA_VAR_RELAY       2'h2
`define RLA_VAR_LEVEL       2'h3

// Output tags
`define RLA_TAG_PLAIN       2'h0
`define RLA_TAG_RELAY       2'h1
`define RLA_TAG_LEVEL       2'h2

`endif

// ---- rla_link_addr.v ----
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "rla_defines.vh"

module rla_link_addr #(
   parameter MAX_ROUTE = 11
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   // Avalon-MM slave
   input  wire [6:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [3:0]  avs_byteenable_i,
   input  wire [31:0] avs_writedata_i,
   output reg  [31:0] avs_readdata_o,
   output reg         avs_waitrequest_o,
   // Transmit command from the user controller
   input  wire        cmd_valid_i,
   input  wire [1:0]  cmd_variant_i,
   input  wire        cmd_ack_req_i,
   input  wire [3:0]  cmd_inline_len_i,
   input  wire [87:0] cmd_inline_route_i,
   output reg         cmd_done_o,
   output reg         cmd_error_o,
   // Outgoing packet header
   output reg         tx_valid_o,
   output reg         tx_relay_o,
   output reg  [1:0]  tx_variant_o,
   output reg         tx_ack_req_o,
   output reg  [15:0] tx_user_id_o,
   output reg  [7:0]  tx_group_id_o,
   output reg  [6:0]  tx_channel_o,
   output reg  [7:0]  tx_src_id_o,
   output reg  [7:0]  tx_dest_id_o,
   output reg  [3:0]  tx_hops_o,
   output reg  [79:0] tx_route_list_o,
   // Received packet header from the demodulator
   input  wire        rx_valid_i,
   input  wire        rx_crc_ok_i,
   input  wire [15:0] rx_user_id_i,
   input  wire [7:0]  rx_group_id_i,
   input  wire [6:0]  rx_channel_i,
   input  wire [7:0]  rx_src_id_i,
   input  wire [7:0]  rx_dest_id_i,
   input  wire [3:0]  rx_hops_i,
   input  wire [79:0] rx_route_list_i,
   input  wire [1:0]  rx_variant_i,
   input  wire        rx_ack_req_i,
   input  wire [7:0]  rx_level_i,
   // Delivery to the user controller
   output reg         dlv_valid_o,
   output reg  [1:0]  dlv_tag_o,
   output reg         dlv_level_en_o,
   output reg  [7:0]  dlv_level_o,
   output reg  [7:0]  dlv_src_id_o,
   // Acknowledge back to the source
   output reg         ack_valid_o,
   output reg  [7:0]  ack_dest_id_o,
   output reg  [7:0]  ack_level_o
);

   // Link parameter registers
   reg [15:0] user_id_q;                // Own user id
   reg [7:0]  group_id_q;               // Own group id
   reg [7:0]  equipment_id_q;           // Own equipment id
   reg [7:0]  destination_id_q;         // Destination for basic sends
   reg [6:0]  channel_q;                // Radio channel
   reg        lvl_en_q;                 // Level prefix for variant two
   reg [3:0]  route_len_q;              // Stored route length, 0 = none
   reg [7:0]  route_list_q [0:MAX_ROUTE-1]; // Stored route entries
   reg [7:0]  acc_cnt_q;                // Delivered packets
   reg [7:0]  dis_cnt_q;                // Discarded packets
   reg [7:0]  rly_cnt_q;                // Relayed packets

   // Bus decode
   // Only the take edge does work; the answer cycle is ignored
   wire       bus_req   = (avs_read_i | avs_write_i) & avs_waitrequest_o;
   wire       bus_wr    = bus_req & avs_write_i;
   wire       rt_hit    = (avs_address_i >= `RLA_OFF_ROUTE_BASE) &&
                          (avs_address_i[6:2] < (5'h08 + MAX_ROUTE[4:0]));
   wire [3:0] rt_idx    = avs_address_i[5:2] - 4'h8;
   wire [31:0] be_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                           {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

   // Byte-lane merge of old and new register contents
   // Lanes left disabled keep the old bits
   function [31:0] be_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [31:0] mask;
      begin
         be_merge = (old_v & ~mask) | (new_v & mask);
      end
   endfunction

   // Merged candidate values for registers with refused encodings
   // Other registers merge against zero, so they need lane 0
   wire [31:0] uid_new = be_merge({16'h0000, user_id_q}, avs_writedata_i, be_mask);
   wire [31:0] eid_new = be_merge({24'h000000, equipment_id_q}, avs_writedata_i, be_mask);
   wire [31:0] gen_new = be_merge(32'h00000000, avs_writedata_i, be_mask);

   // Route selection for transmit commands
   reg [3:0]  sel_len;                  // Chosen route length
   reg [7:0]  sel_id [0:MAX_ROUTE-1];   // Chosen route entries
   reg [79:0] sel_rest;                 // Entries after the first hop
   integer    i;                        // Route mux index
   integer    j;                        // Reset loop index, kept apart from the mux

   // Inline list wins over the stored route register
   always @* begin
      if (cmd_inline_len_i != 4'h0) begin
         sel_len = cmd_inline_len_i;
         for (i = 0; i < MAX_ROUTE; i = i + 1)
            sel_id[i] = cmd_inline_route_i[i*8 +: 8];
      end else begin
         sel_len = route_len_q;
         for (i = 0; i < MAX_ROUTE; i = i + 1)
            sel_id[i] = route_list_q[i];
      end
      sel_rest = 80'h0;
      for (i = 1; i < MAX_ROUTE; i = i + 1)
         sel_rest[(i-1)*8 +: 8] = sel_id[i];
   end

   // Receive classification
   // Each check is a plain compare of this cycle's header; nothing is
   // kept from earlier packets, so a packet is judged on its own fields
   wire link_ok  = rx_crc_ok_i &
                   (rx_user_id_i == user_id_q) &
                   (rx_group_id_i == group_id_q) &
                   (rx_channel_i == channel_q);
   wire dest_nul = (rx_dest_id_i == `RLA_ID_NULL);
   wire dest_me  = (rx_dest_id_i == equipment_id_q);
   // Special own id of FFh listens to every addressed packet with no hops left
   wire eid_mon  = (equipment_id_q == `RLA_EID_SPECIAL);
   wire dest_bc  = (rx_dest_id_i == `RLA_ID_BROADCAST) &
                   (rx_variant_i == `RLA_VAR_BASIC);
   wire rx_rly   = rx_valid_i & link_ok & ~dest_nul & dest_me &
                   ~eid_mon & (rx_hops_i != 4'h0);
   wire rx_tgt   = rx_valid_i & link_ok & ~dest_nul &
                   (rx_hops_i == 4'h0) & (dest_me | eid_mon | dest_bc);
   wire rx_drop  = rx_valid_i & ~rx_rly & ~rx_tgt;

   // Command length check; a relay in the same cycle defers the command
   wire cmd_multi = (cmd_variant_i != `RLA_VAR_BASIC);
   wire cmd_bad   = cmd_multi & (sel_len > `RLA_MAX_ROUTE);
   // A command still held high while its done or error pulse stands
   // is the same command; taking it again would send it twice
   wire cmd_take  = cmd_valid_i & ~rx_rly & ~cmd_done_o & ~cmd_error_o;

   // Avalon slave and register file
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h00000000;
         user_id_q         <= `RLA_RST_USER_ID;
         group_id_q        <= `RLA_RST_GROUP_ID;
         equipment_id_q    <= `RLA_RST_EQUIP_ID;
         destination_id_q  <= `RLA_RST_DEST_ID;
         channel_q         <= `RLA_RST_CHANNEL;
         lvl_en_q          <= 1'b0;
         route_len_q       <= `RLA_RST_ROUTE_LEN;
         // Stored route cleared so an empty list reads as zeros
         for (j = 0; j < MAX_ROUTE; j = j + 1)
            route_list_q[j] <= 8'h00;
      end else begin
         // One wait cycle, then answer; next request waits again
         avs_waitrequest_o <= ~bus_req;
         if (bus_req) begin
            avs_readdata_o <= 32'h00000000;
            if (avs_read_i) begin
               case (avs_address_i)
                  `RLA_OFF_USER_ID:   avs_readdata_o <= {16'h0000, user_id_q};
                  `RLA_OFF_GROUP_ID:  avs_readdata_o <= {24'h000000, group_id_q};
                  `RLA_OFF_EQUIP_ID:  avs_readdata_o <= {24'h000000, equipment_id_q};
                  `RLA_OFF_DEST_ID:   avs_readdata_o <= {24'h000000, destination_id_q};
                  `RLA_OFF_CHANNEL:   avs_readdata_o <= {25'h0000000, channel_q};
                  `RLA_OFF_CTRL:      avs_readdata_o <= {31'h00000000, lvl_en_q};
                  `RLA_OFF_ROUTE_LEN: avs_readdata_o <= {28'h0000000, route_len_q};
                  `RLA_OFF_STATUS:
                     avs_readdata_o <= {8'h00, rly_cnt_q, dis_cnt_q, acc_cnt_q};
                  default: begin
                     // Route entries, else unmapped reads as zero
                     if (rt_hit)
                        avs_readdata_o <= {24'h000000, route_list_q[rt_idx]};
                  end
               endcase
            end
         end
         // Parameters change freely between transmissions
         if (bus_wr) begin
            case (avs_address_i)
               `RLA_OFF_USER_ID: begin
                  // Forbidden user id is refused, old value kept
                  if (uid_new[15:0] != `RLA_UID_FORBIDDEN)
                     user_id_q <= uid_new[15:0];
               end
               `RLA_OFF_GROUP_ID:  group_id_q <= gen_new[7:0];
               `RLA_OFF_EQUIP_ID: begin
                  // Zero is the broadcast address, not a station id
                  if (eid_new[7:0] != `RLA_ID_BROADCAST)
                     equipment_id_q <= eid_new[7:0];
               end
               `RLA_OFF_DEST_ID:   destination_id_q <= gen_new[7:0];
               `RLA_OFF_CHANNEL:   channel_q <= gen_new[6:0];
               `RLA_OFF_CTRL:      lvl_en_q <= gen_new[`RLA_CTRL_LVL_BIT];
               `RLA_OFF_ROUTE_LEN: begin
                  // Over-long lists are refused outright
                  if (gen_new[3:0] <= `RLA_MAX_ROUTE)
                     route_len_q <= gen_new[3:0];
               end
               default: begin
                  // Route entry; unmapped writes are dropped
                  if (rt_hit)
                     route_list_q[rt_idx] <= gen_new[7:0];
               end
            endcase
         end
      end
   end

   // Event counters, wrap at 255
   // At most one rises per header, since relay, target and drop
   // are mutually exclusive
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         acc_cnt_q <= 8'h00;
         dis_cnt_q <= 8'h00;
         rly_cnt_q <= 8'h00;
      end else begin
         if (rx_tgt)
            acc_cnt_q <= acc_cnt_q + 8'h01;
         if (rx_drop)
            dis_cnt_q <= dis_cnt_q + 8'h01;
         if (rx_rly)
            rly_cnt_q <= rly_cnt_q + 8'h01;
      end
   end

   // Outgoing header: relay forward has priority over a new command
   // A deferred command simply waits; its valid is still high next cycle
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_valid_o      <= 1'b0;
         tx_relay_o      <= 1'b0;
         tx_variant_o    <= `RLA_VAR_BASIC;
         tx_ack_req_o    <= 1'b0;
         tx_user_id_o    <= 16'h0000;
         tx_group_id_o   <= 8'h00;
         tx_channel_o    <= 7'h00;
         tx_src_id_o     <= 8'h00;
         tx_dest_id_o    <= 8'h00;
         tx_hops_o       <= 4'h0;
         tx_route_list_o <= 80'h0;
         cmd_done_o      <= 1'b0;
         cmd_error_o     <= 1'b0;
      end else begin
         tx_valid_o  <= 1'b0;
         tx_relay_o  <= 1'b0;
         cmd_done_o  <= 1'b0;
         cmd_error_o <= 1'b0;
         if (rx_rly) begin
            // Header passes straight on; payload is never held here
            tx_valid_o      <= 1'b1;
            tx_relay_o      <= 1'b1;
            tx_variant_o    <= rx_variant_i;
            tx_ack_req_o    <= rx_ack_req_i;
            tx_user_id_o    <= rx_user_id_i;
            tx_group_id_o   <= rx_group_id_i;
            tx_channel_o    <= rx_channel_i;
            tx_src_id_o     <= rx_src_id_i;
            tx_dest_id_o    <= rx_route_list_i[7:0];
            tx_hops_o       <= rx_hops_i - 4'h1;
            tx_route_list_o <= {8'h00, rx_route_list_i[79:8]};
         end else if (cmd_take) begin
            if (cmd_bad) begin
               cmd_error_o <= 1'b1;
            end else begin
               cmd_done_o    <= 1'b1;
               tx_valid_o    <= 1'b1;
               tx_variant_o  <= cmd_variant_i;
               // Basic sends carry no acknowledge request
               tx_ack_req_o  <= cmd_ack_req_i & cmd_multi;
               tx_user_id_o  <= user_id_q;
               tx_group_id_o <= group_id_q;
               tx_channel_o  <= channel_q;
               tx_src_id_o   <= equipment_id_q;
               if (cmd_multi && (sel_len != 4'h0)) begin
                  // First entry is next hop; one entry is the target
                  tx_dest_id_o    <= sel_id[0];
                  tx_hops_o       <= sel_len - 4'h1;
                  tx_route_list_o <= sel_rest;
               end else begin
                  // Destination register, even if FFh or broadcast
                  tx_dest_id_o    <= destination_id_q;
                  tx_hops_o       <= 4'h0;
                  tx_route_list_o <= 80'h0;
               end
            end
         end
      end
   end

   // Level and source are captured even when no prefix is shown,
   // so the user side always sees the header of the last delivery
   // Delivery and acknowledge at the target
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         dlv_valid_o    <= 1'b0;
         dlv_tag_o      <= `RLA_TAG_PLAIN;
         dlv_level_en_o <= 1'b0;
         dlv_level_o    <= 8'h00;
         dlv_src_id_o   <= 8'h00;
         ack_valid_o    <= 1'b0;
         ack_dest_id_o  <= 8'h00;
         ack_level_o    <= 8'h00;
      end else begin
         dlv_valid_o <= 1'b0;
         ack_valid_o <= 1'b0;
         // Dropped packets leave every output quiet
         if (rx_tgt) begin
            dlv_valid_o  <= 1'b1;
            dlv_level_o  <= rx_level_i;
            dlv_src_id_o <= rx_src_id_i;
            case (rx_variant_i)
               `RLA_VAR_RELAY: begin
                  dlv_tag_o      <= `RLA_TAG_RELAY;
                  dlv_level_en_o <= lvl_en_q;
               end
               `RLA_VAR_LEVEL: begin
                  dlv_tag_o      <= `RLA_TAG_LEVEL;
                  dlv_level_en_o <= 1'b1;
               end
               default: begin
                  dlv_tag_o      <= `RLA_TAG_PLAIN;
                  dlv_level_en_o <= 1'b0;
               end
            endcase
            // Only error-free packets from the multi-hop variants ack
            if (rx_ack_req_i && (rx_variant_i != `RLA_VAR_BASIC)) begin
               ack_valid_o   <= 1'b1;
               ack_dest_id_o <= rx_src_id_i;
               ack_level_o   <= rx_level_i;
            end
         end
      end
   end

endmodule

// ---- rla_peer_model.sv ----
`timescale 1ns/1ns
// Far-side station: sends one received header on request
module rla_peer_model (
   input  wire         clk_i,
   input  wire         send_i,
   input  wire [142:0] hdr_i,
   output reg          vld_o,
   output reg  [142:0] hdr_o
);
   // Quiet lines before the first frame
   initial begin
      vld_o = 1'b0;
      hdr_o = 143'h0;
   end
   // Header stands in its valid cycle; after it, the lines toggle every cycle, so the old header shows again every second cycle
   always @(posedge clk_i) begin
      vld_o <= send_i;
      hdr_o <= send_i ? hdr_i : ~hdr_o;
   end
endmodule

// ---- rla_link_addr_checker.sv ----
`timescale 1ns/1ns
`include "rla_defines.vh"
// Port-level timing and filtering checks
module rla_link_addr_checker #(
   parameter MAX_ROUTE = 11
) (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire        avs_waitrequest_o,
   input wire        cmd_valid_i,
   input wire [3:0]  cmd_inline_len_i,
   input wire        cmd_done_o,
   input wire        cmd_error_o,
   input wire        tx_valid_o,
   input wire        tx_relay_o,
   input wire [3:0]  tx_hops_o,
   input wire [7:0]  tx_dest_id_o,
   input wire [79:0] tx_route_list_o,
   input wire        rx_valid_i,
   input wire        rx_crc_ok_i,
   input wire [7:0]  rx_src_id_i,
   input wire [3:0]  rx_hops_i,
   input wire [79:0] rx_route_list_i,
   input wire [7:0]  rx_level_i,
   input wire        dlv_valid_o,
   input wire [1:0]  dlv_tag_o,
   input wire        dlv_level_en_o,
   input wire [7:0]  dlv_level_o,
   input wire        ack_valid_o,
   input wire [7:0]  ack_dest_id_o,
   input wire [7:0]  ack_level_o
);
   wire [7:0] rt_lo = rx_route_list_i[7:0]; // First route entry
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_wait;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");
   property p_wait_one;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("bus answer too long");
   // A too long inline route is refused in the next cycle
   property p_long;
      cmd_valid_i && !cmd_done_o && !cmd_error_o && !rx_valid_i
         && cmd_inline_len_i > MAX_ROUTE |=> cmd_error_o && !tx_valid_o;
   endproperty
   a_long: assert property (p_long) else $error("long route accepted");
   property p_done;
      cmd_done_o |-> tx_valid_o && !tx_relay_o && !cmd_error_o;
   endproperty
   a_done: assert property (p_done) else $error("done without header");
   // Forwarding is immediate, one hop down the list
   property p_relay;
      tx_relay_o |-> $past(rx_valid_i) && tx_valid_o && tx_dest_id_o == $past(rt_lo)
         && tx_hops_o == $past(rx_hops_i) - 4'h1
         && tx_route_list_o == {8'h00, $past(rx_route_list_i[79:8])};
   endproperty
   a_relay: assert property (p_relay) else $error("bad relay forward");
   property p_crc;
      rx_valid_i && !rx_crc_ok_i |=> !dlv_valid_o && !ack_valid_o && !tx_relay_o;
   endproperty
   a_crc: assert property (p_crc) else $error("bad packet used");
   property p_lvl;
      dlv_valid_o && dlv_tag_o == `RLA_TAG_LEVEL |-> dlv_level_en_o
         && dlv_level_o == $past(rx_level_i);
   endproperty
   a_lvl: assert property (p_lvl) else $error("level prefix missing");
   property p_ack;
      ack_valid_o |-> dlv_valid_o && ack_dest_id_o == $past(rx_src_id_i)
         && ack_level_o == $past(rx_level_i);
   endproperty
   a_ack: assert property (p_ack) else $error("bad acknowledge");
endmodule
bind rla_link_addr rla_link_addr_checker #(.MAX_ROUTE(MAX_ROUTE)) u_chk (.*);

// ---- rla_link_addr_tb_top.sv ----
`timescale 1ns/1ns
`include "rla_defines.vh"
// Compares one value, counts and reports
`define RLA_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module rla_link_addr_tb_top;
   logic         clk_i = 1'b0, rst_n_i = 1'b0;
   logic [6:0]   avs_address_i = 7'h00;
   logic         avs_read_i = 1'b0, avs_write_i = 1'b0, cmd_valid_i = 1'b0, cmd_ack_req_i = 1'b0;
   logic [3:0]   avs_byteenable_i = 4'hF, cmd_inline_len_i = 4'h0;
   logic [31:0]  avs_writedata_i = 32'h0, rnd = 32'h26;
   logic [63:0]  e, g;                   // Popped note and observed word
   logic [1:0]   cmd_variant_i = 2'h1;
   logic [87:0]  cmd_inline_route_i = 88'h0;
   wire  [31:0]  avs_readdata_o;
   wire          avs_waitrequest_o, cmd_done_o, cmd_error_o, tx_valid_o, tx_relay_o, tx_ack_req_o;
   wire          rx_valid_i, rx_crc_ok_i, rx_ack_req_i, dlv_valid_o, dlv_level_en_o, ack_valid_o;
   wire  [1:0]   tx_variant_o, dlv_tag_o, rx_variant_i;
   wire  [15:0]  tx_user_id_o, rx_user_id_i;
   wire  [7:0]   tx_group_id_o, tx_src_id_o, tx_dest_id_o, dlv_level_o, dlv_src_id_o;
   wire  [7:0]   rx_group_id_i, rx_src_id_i, rx_dest_id_i, rx_level_i, ack_dest_id_o, ack_level_o;
   wire  [6:0]   tx_channel_o, rx_channel_i;
   wire  [3:0]   tx_hops_o, rx_hops_i;
   wire  [79:0]  tx_route_list_o, rx_route_list_i;
   wire  [142:0] hdr_w;                  // Header from the far station
   logic [142:0] peer_hdr = 143'h0;
   logic         peer_send = 1'b0, lvl_on = 1'b0;
   logic [63:0]  expq[$];                // Expected results, oldest first
   int           num_errors = 0, n_compared = 0, n_dlv = 0, n_disc = 0, n_rly = 0;
   logic [15:0]  uid;
   logic [7:0]   gid;
   logic [6:0]   chn;
   assign {rx_crc_ok_i, rx_user_id_i, rx_group_id_i, rx_channel_i, rx_src_id_i, rx_dest_id_i,
           rx_hops_i, rx_route_list_i, rx_variant_i, rx_ack_req_i, rx_level_i} = hdr_w;
   rla_link_addr dut (.*);
   rla_peer_model u_peer (.clk_i(clk_i), .send_i(peer_send), .hdr_i(peer_hdr),
                          .vld_o(rx_valid_i), .hdr_o(hdr_w));
   // 20 MHz clock
   initial forever #25 clk_i = ~clk_i;
   function automatic logic [31:0] xs();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd;
   endfunction
   // Empty queue yields unknown, so an unexpected event always mismatches
   function automatic logic [63:0] pop();
      if (expq.size() == 0) return {64{1'bx}};
      return expq.pop_front();
   endfunction
   // Own commands carry own user id, channel and station id 33h
   function automatic logic [63:0] txw(logic rl, logic ak, logic [1:0] v, logic [3:0] h,
                                       logic [7:0] d);
      return {uid, 1'b0, chn, 8'h33, 4'h2, rl, ak, v, h, 4'h0, d, gid};
   endfunction
   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
      @(posedge clk_i);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= wr;
      avs_read_i      <= !wr;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [31:0] x);
      expq.push_back({32'h0, x});
      bus(1'b0, a, 32'h0);
   endtask
   // Transmit command, held until done or error
   task automatic cmd(input logic [1:0] v, input logic ak, input logic [3:0] n,
                      input logic [87:0] r, input logic [63:0] x);
      expq.push_back(x);
      @(posedge clk_i);
      cmd_variant_i      <= v;
      cmd_ack_req_i      <= ak;
      cmd_inline_len_i   <= n;
      cmd_inline_route_i <= r;
      cmd_valid_i        <= 1'b1;
      do @(posedge clk_i); while (cmd_done_o !== 1'b1 && cmd_error_o !== 1'b1);
      cmd_valid_i <= 1'b0;
   endtask
   // Received packet; k: 0 dropped, 1 delivered, 2 relayed
   task automatic rx(input logic ok, input logic [15:0] u, input logic [7:0] g,
                     input logic [6:0] c, input logic [7:0] d, input logic [3:0] h,
                     input logic [1:0] v, input logic ak, input int k);
      logic [7:0] s, l;
      logic [1:0] tg;
      logic       le;
      s  = 8'(xs());
      l  = 8'(xs());
      tg = (v == 2'h3) ? `RLA_TAG_LEVEL : (v == 2'h2) ? `RLA_TAG_RELAY : `RLA_TAG_PLAIN;
      le = (v == 2'h3) || (v == 2'h2 && lvl_on);
      if (k == 1)
         expq.push_back({32'h0, 4'h1, 1'b0, ak && v != 2'h1, tg, le, 7'h0, le ? l : 8'h0, s});
      if (k == 2) expq.push_back({u, 1'b0, c, s, 32'(txw(1'b1, ak, v, h - 4'h1, 8'h66))});
      n_disc += (k == 0);
      n_dlv  += (k == 1);
      n_rly  += (k == 2);
      @(posedge clk_i);
      peer_hdr  <= {ok, u, g, c, s, d, h, 80'h7766, v, ak, l};
      peer_send <= 1'b1;
      @(posedge clk_i);
      peer_send <= 1'b0;
   endtask
   // Output watcher: each event takes the oldest note
   always @(posedge clk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
         e = pop();
         `RLA_CHK({32'h0, avs_readdata_o}, e)
      end
      if (cmd_error_o === 1'b1) begin
         e = pop();
         `RLA_CHK(64'h3, e)
      end
      if (tx_valid_o === 1'b1) begin
         e = pop();
         g = {tx_user_id_o, 1'b0, tx_channel_o, tx_src_id_o, 4'h2, tx_relay_o, tx_ack_req_o,
              tx_variant_o, tx_hops_o, 4'h0, tx_dest_id_o, tx_group_id_o};
         `RLA_CHK(g, e)
      end
      if (dlv_valid_o === 1'b1) begin
         e = pop();
         g = {32'h0, 4'h1, 1'b0, ack_valid_o, dlv_tag_o, dlv_level_en_o, 7'h0,
              dlv_level_en_o ? dlv_level_o : 8'h0, dlv_src_id_o};
         `RLA_CHK(g, e)
      end
   end
   task automatic end_of_test();
      $display("Counts: %0d compared, %0d mismatched", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog at 5000 cycles, far beyond the some 130 cycles needed
   initial begin
      #(50 * 5000);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end
   initial begin
      uid = (16'(xs()) & 16'h7FFF) | 16'h0100;
      gid = 8'(xs());
      chn = 7'(xs());
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(`RLA_OFF_USER_ID, 32'h0);
      rd(`RLA_OFF_EQUIP_ID, 32'h1);
      rd(7'h60, 32'h0);
      bus(1'b1, `RLA_OFF_USER_ID, 32'hFFFF);
      rd(`RLA_OFF_USER_ID, 32'h0);
      bus(1'b1, `RLA_OFF_EQUIP_ID, 32'h0);
      rd(`RLA_OFF_EQUIP_ID, 32'h1);
      bus(1'b1, `RLA_OFF_ROUTE_LEN, 32'hC);
      rd(`RLA_OFF_ROUTE_LEN, 32'h0);
      bus(1'b1, `RLA_OFF_USER_ID, {16'h0, uid});
      bus(1'b1, `RLA_OFF_GROUP_ID, {24'h0, gid});
      bus(1'b1, `RLA_OFF_EQUIP_ID, 32'h33);
      bus(1'b1, `RLA_OFF_DEST_ID, 32'h44);
      bus(1'b1, `RLA_OFF_CHANNEL, {25'h0, chn});
      rd(`RLA_OFF_USER_ID, {16'h0, uid});
      $display("registers finished");
      cmd(2'h1, 1'b1, 4'h0, 88'h0, txw(1'b0, 1'b0, 2'h1, 4'h0, 8'h44));
      cmd(2'h2, 1'b1, 4'h3, 88'h030201, txw(1'b0, 1'b1, 2'h2, 4'h2, 8'h01));
      cmd(2'h3, 1'b0, 4'h1, 88'h99, txw(1'b0, 1'b0, 2'h3, 4'h0, 8'h99));
      cmd(2'h2, 1'b0, 4'hC, 88'h0, 64'h3);
      bus(1'b1, `RLA_OFF_ROUTE_LEN, 32'h2);
      bus(1'b1, `RLA_OFF_ROUTE_BASE, 32'h71);
      bus(1'b1, `RLA_OFF_ROUTE_BASE + 7'h04, 32'h72);
      cmd(2'h2, 1'b0, 4'h0, 88'h0, txw(1'b0, 1'b0, 2'h2, 4'h1, 8'h71));
      cmd(2'h3, 1'b0, 4'h1, 88'h5A, txw(1'b0, 1'b0, 2'h3, 4'h0, 8'h5A));
      bus(1'b1, `RLA_OFF_DEST_ID, 32'h45);
      cmd(2'h1, 1'b0, 4'h0, 88'h0, txw(1'b0, 1'b0, 2'h1, 4'h0, 8'h45));
      $display("commands finished");
      rx(1'b1, uid, gid, chn, 8'h33, 4'h0, 2'h1, 1'b0, 1);
      rx(1'b1, uid, gid, chn, 8'h00, 4'h0, 2'h1, 1'b0, 1);
      rx(1'b1, uid, gid, chn, 8'h00, 4'h0, 2'h2, 1'b0, 0);
      rx(1'b1, uid, gid, chn, 8'hFF, 4'h0, 2'h1, 1'b0, 0);
      rx(1'b1, uid, gid, chn, 8'h50, 4'h0, 2'h1, 1'b0, 0);
      rx(1'b0, uid, gid, chn, 8'h33, 4'h0, 2'h2, 1'b1, 0);
      rx(1'b1, 16'hFFFF, gid, chn, 8'h33, 4'h0, 2'h1, 1'b0, 0);
      rx(1'b1, uid, gid ^ 8'h01, chn, 8'h33, 4'h0, 2'h1, 1'b0, 0);
      rx(1'b1, uid, gid, chn ^ 7'h01, 8'h33, 4'h0, 2'h1, 1'b0, 0);
      rx(1'b1, uid, gid, chn, 8'h33, 4'h0, 2'h2, 1'b1, 1);
      rx(1'b1, uid, gid, chn, 8'h33, 4'h0, 2'h3, 1'b1, 1);
      bus(1'b1, `RLA_OFF_CTRL, 32'h1);
      lvl_on = 1'b1;
      rx(1'b1, uid, gid, chn, 8'h33, 4'h0, 2'h2, 1'b0, 1);
      rx(1'b1, uid, gid, chn, 8'h33, 4'h2, 2'h2, 1'b1, 2);
      bus(1'b1, `RLA_OFF_EQUIP_ID, 32'hFF);
      rx(1'b1, uid, gid, chn, 8'h50, 4'h0, 2'h1, 1'b0, 1);
      rd(`RLA_OFF_STATUS, {8'h00, 8'(n_rly), 8'(n_disc), 8'(n_dlv)});
      $display("receive finished");
      repeat (4) @(posedge clk_i);
      if (expq.size() != 0) num_errors++;
      end_of_test();
   end
endmodule
